// ---- rtl/adsq_pkg.sv ----
// constants, register map and types of the a/d sequencer control block
// assumes a classic wishbone slave with 32-bit data and byte addresses
package adsq_pkg;

   localparam int ADSQ_RES_BITS = 10;
   localparam int ADSQ_CHANNELS = 12;

   // register byte offsets
   localparam logic [7:0] ADSQ_STATUS_OFS = 8'h00;
   localparam logic [7:0] ADSQ_CTRL_OFS   = 8'h04;
   localparam logic [7:0] ADSQ_DATA_OFS   = 8'h10;

   // status register fields
   localparam int ADSQ_DONE_BIT = 7;
   localparam int ADSQ_IEN_BIT  = 6;
   localparam int ADSQ_RUN_BIT  = 5;
   localparam int ADSQ_SCAN_BIT = 4;

   // control register fields
   localparam int ADSQ_TRG_LSB = 6;
   localparam int ADSQ_SPD_LSB = 2;
   localparam logic [7:0] ADSQ_CTRL_ONES = 8'h33;
   localparam logic [7:0] ADSQ_CTRL_RST  = 8'h33;

   localparam logic [1:0] ADSQ_TRG_SOFT  = 2'h0;
   localparam logic [1:0] ADSQ_TRG_TIMER = 2'h1;
   localparam logic [1:0] ADSQ_TRG_EXT   = 2'h3;

   // conversion times in states; one state is one clock_in cycle
   localparam logic [9:0] ADSQ_T_SINGLE_0 = 10'h212; // 530
   localparam logic [9:0] ADSQ_T_SINGLE_1 = 10'h10a; // 266
   localparam logic [9:0] ADSQ_T_SINGLE_2 = 10'h086; // 134
   localparam logic [9:0] ADSQ_T_SINGLE_3 = 10'h044; // 68
   localparam logic [9:0] ADSQ_T_SCAN_0   = 10'h200; // 512
   localparam logic [9:0] ADSQ_T_SCAN_1   = 10'h100; // 256
   localparam logic [9:0] ADSQ_T_SCAN_2   = 10'h080; // 128
   localparam logic [9:0] ADSQ_T_SCAN_3   = 10'h040; // 64

   typedef enum logic [1:0] {
      ADSQ_IDLE   = 2'b00,
      ADSQ_SETTLE = 2'b01,
      ADSQ_CONV   = 2'b10
   } adsq_state_type;

   // conversion length in states for speed code and first/later flag
   function automatic logic [9:0] adsq_conv_states(input logic [1:0] spd,
                                                  input logic later);
      logic [9:0] t;
      t = ADSQ_T_SINGLE_0;
      unique case (spd)
         2'b00: t = later ? ADSQ_T_SCAN_0 : ADSQ_T_SINGLE_0;
         2'b01: t = later ? ADSQ_T_SCAN_1 : ADSQ_T_SINGLE_1;
         2'b10: t = later ? ADSQ_T_SCAN_2 : ADSQ_T_SINGLE_2;
         2'b11: t = later ? ADSQ_T_SCAN_3 : ADSQ_T_SINGLE_3;
      endcase
      return t;
   endfunction

endpackage

// ---- rtl/adsq_sar.sv ----
// successive-approximation engine: one 10-bit result per start
// assumes comparator_in answers for the trial code of the current cycle
`timescale 1ns/1ps
module adsq_sar #(
   parameter int RES_BITS = 10
) (
   input  wire logic                clock_in,
   input  wire logic                resetn_in,
   input  wire logic                start_in,
   input  wire logic                abort_in,
   input  wire logic                comparator_in,
   output logic [RES_BITS-1:0]      trial_out,
   output logic [RES_BITS-1:0]      result_out,
   output logic                     done_out
);
   import adsq_pkg::*;

   initial begin
      if (RES_BITS < 2 || RES_BITS > 16)
         $error("adsq_sar: RES_BITS out of range");
   end

   logic [RES_BITS-1:0] code_r, code_nxt;
   logic [RES_BITS-1:0] bit_r, bit_nxt;
   logic [RES_BITS-1:0] res_r, res_nxt;
   logic                done_r, done_nxt;

   // one bit decided per cycle, msb first
   always_comb begin
      code_nxt = code_r;
      bit_nxt  = bit_r;
      res_nxt  = res_r;
      done_nxt = 1'b0;
      if (abort_in) begin
         bit_nxt = '0;
      end else if (start_in) begin
         bit_nxt  = {1'b1, {(RES_BITS-1){1'b0}}};
         code_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
      end else if (bit_r != '0) begin
         code_nxt = comparator_in ? code_r : (code_r & ~bit_r);
         code_nxt = code_nxt | (bit_r >> 1);
         bit_nxt  = bit_r >> 1;
         if (bit_r[0]) begin
            res_nxt  = comparator_in ? code_r : (code_r & ~bit_r);
            done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         code_r <= '0;
         bit_r  <= '0;
         res_r  <= '0;
         done_r <= 1'b0;
      end else begin
         code_r <= code_nxt;
         bit_r  <= bit_nxt;
         res_r  <= res_nxt;
         done_r <= done_nxt;
      end
   end

   assign trial_out  = code_r;
   assign result_out = res_r;
   assign done_out   = done_r;

endmodule // adsq_sar

// ---- rtl/adsq_wb_slave.sv ----
// classic wishbone slave handshake: one ack per access, one wait state
// assumes a master that holds the request until it sees ack
`timescale 1ns/1ps
module adsq_wb_slave (
   input  wire logic clock_in,
   input  wire logic resetn_in,
   input  wire logic cyc_in,
   input  wire logic stb_in,
   input  wire logic we_in,
   output logic      wr_fire_out,
   output logic      rd_fire_out,
   output logic      ack_out
);
   import adsq_pkg::*;

   logic ack_r, ack_nxt;

   // ack in the cycle after the request, dropped the cycle after
   always_comb begin
      ack_nxt = cyc_in && stb_in && !ack_r;
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in)
         ack_r <= 1'b0;
      else
         ack_r <= ack_nxt;
   end

   assign ack_out     = ack_r;
   // writes land at the edge that samples ack
   assign wr_fire_out = ack_r && cyc_in && stb_in && we_in;
   assign rd_fire_out = ack_r && cyc_in && stb_in && !we_in;

endmodule // adsq_wb_slave

// ---- rtl/adsq_top.sv ----
// a/d converter sequencer control: registers, triggers, single/scan runs
// assumes an analog comparator answering the trial code each cycle
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module adsq_top #(
   parameter int RES_BITS = 10,
   parameter int SETTLE   = 4
) (
   input  wire logic                 clock_in,
   input  wire logic                 resetn_in,
   input  wire logic                 wb_cyc_in,
   input  wire logic                 wb_stb_in,
   input  wire logic                 wb_we_in,
   input  wire logic [7:0]           wb_adr_in,
   input  wire logic [3:0]           wb_sel_in,
   input  wire logic [31:0]          wb_dat_in,
   output logic [31:0]               wb_dat_out,
   output logic                      wb_ack_out,
   input  wire logic                 timer_trigger_in,
   input  wire logic                 ext_trigger_pin_in,
   input  wire logic                 comparator_in,
   output logic [RES_BITS-1:0]       trial_code_out,
   output logic [3:0]                sample_channel_out,
   output logic                      done_interrupt_out
);
   import adsq_pkg::*;

   initial begin
      if (RES_BITS != ADSQ_RES_BITS)
         $error("adsq_top: only 10-bit results are served");
      if (SETTLE < 1 || SETTLE > 60)
         $error("adsq_top: SETTLE must be 1..60");
   end

   ////////////////////////////////////////////////////////////////////
   // bus slave
   logic wr_fire;

   adsq_wb_slave u_wb (
      .clock_in    (clock_in),
      .resetn_in   (resetn_in),
      .cyc_in      (wb_cyc_in),
      .stb_in      (wb_stb_in),
      .we_in       (wb_we_in),
      .wr_fire_out (wr_fire),
      .rd_fire_out (),
      .ack_out     (wb_ack_out)
   );

   logic wr_stat, wr_ctrl;
   assign wr_stat = wr_fire && wb_adr_in == ADSQ_STATUS_OFS && wb_sel_in[0];
   assign wr_ctrl = wr_fire && wb_adr_in == ADSQ_CTRL_OFS && wb_sel_in[0];

   ////////////////////////////////////////////////////////////////////
   // registers and sequencer state
   logic [7:0]          ctrl_r, ctrl_nxt;
   logic                done_r, done_nxt;
   logic                ien_r, ien_nxt;
   logic                run_r, run_nxt;
   logic                scan_r, scan_nxt;
   logic [3:0]          chsel_r, chsel_nxt;
   logic [3:0]          cur_r, cur_nxt;
   logic                later_r, later_nxt;
   logic [9:0]          cnt_r, cnt_nxt;
   logic                ext_q_r, ext_q_nxt;
   adsq_state_type      st_r, st_nxt;
   logic [RES_BITS-1:0] data_r [ADSQ_CHANNELS];

   logic [1:0] trg, spd;
   assign trg = ctrl_r[ADSQ_TRG_LSB +: 2];
   assign spd = ctrl_r[ADSQ_SPD_LSB +: 2];

   // hardware start sources gated by trigger field
   logic ext_fall, hw_start;
   assign ext_fall = ext_q_r && !ext_trigger_pin_in;
   assign hw_start = (trg == ADSQ_TRG_TIMER && timer_trigger_in) ||
                     (trg == ADSQ_TRG_EXT && ext_fall);

   // the sar engine
   logic                sar_start, sar_abort, sar_done;
   logic [RES_BITS-1:0] sar_result;

   adsq_sar #(.RES_BITS(RES_BITS)) u_sar (
      .clock_in      (clock_in),
      .resetn_in     (resetn_in),
      .start_in      (sar_start),
      .abort_in      (sar_abort),
      .comparator_in (comparator_in),
      .trial_out     (trial_code_out),
      .result_out    (sar_result),
      .done_out      (sar_done)
   );

   // group base and last index
   logic [3:0] first_ch, last_ch;
   assign first_ch = {chsel_r[3:2], 2'b00};
   assign last_ch  = scan_r ? {chsel_r[3:2], chsel_r[1:0]} : chsel_r;

   logic [9:0] conv_len;
   assign conv_len = adsq_conv_states(spd, later_r);

   logic soft_set, soft_clr, result_cycle, go;
   assign soft_set = wr_stat && wb_dat_in[ADSQ_RUN_BIT];
   assign soft_clr = wr_stat && !wb_dat_in[ADSQ_RUN_BIT];
   // conversion ends at the state count; the result is in then
   assign result_cycle = st_r == ADSQ_CONV && cnt_r == 10'h001;
   assign go = !run_r && (soft_set || hw_start);

   // next-state logic of registers and sequencer
   always_comb begin
      ctrl_nxt  = ctrl_r;
      done_nxt  = done_r;
      ien_nxt   = ien_r;
      run_nxt   = run_r;
      scan_nxt  = scan_r;
      chsel_nxt = chsel_r;
      cur_nxt   = cur_r;
      later_nxt = later_r;
      cnt_nxt   = cnt_r;
      st_nxt    = st_r;
      ext_q_nxt = ext_trigger_pin_in;
      sar_start = 1'b0;
      sar_abort = 1'b0;
      // fixed-one bits never stored as anything else
      if (wr_ctrl)
         ctrl_nxt = (wb_dat_in[7:0] & ~ADSQ_CTRL_ONES) | ADSQ_CTRL_ONES;
      if (wr_stat) begin
         // mode, channel and run may change in one write
         ien_nxt   = wb_dat_in[ADSQ_IEN_BIT];
         scan_nxt  = wb_dat_in[ADSQ_SCAN_BIT];
         chsel_nxt = wb_dat_in[3:0];
         run_nxt   = wb_dat_in[ADSQ_RUN_BIT];
         if (!wb_dat_in[ADSQ_DONE_BIT])
            done_nxt = 1'b0;
      end
      if (hw_start)
         run_nxt = 1'b1;
      unique case (st_r)
         ADSQ_IDLE: begin
            if (go) begin
               st_nxt    = ADSQ_SETTLE;
               cnt_nxt   = 10'(SETTLE);
               later_nxt = 1'b0;
               cur_nxt   = (wr_stat ? wb_dat_in[ADSQ_SCAN_BIT] : scan_r)
                         ? {(wr_stat ? wb_dat_in[3:2] : chsel_r[3:2]), 2'b00}
                         : (wr_stat ? wb_dat_in[3:0] : chsel_r);
            end
         end
         ADSQ_SETTLE: begin
            cnt_nxt = cnt_r - 10'h001;
            if (cnt_r == 10'h001) begin
               st_nxt    = ADSQ_CONV;
               sar_start = 1'b1;
               // remaining states after the settle span
               cnt_nxt   = later_r ? conv_len : conv_len - 10'(SETTLE);
            end
         end
         ADSQ_CONV: begin
            cnt_nxt = cnt_r - 10'h001;
            if (result_cycle) begin
               if (!scan_r) begin
                  st_nxt  = ADSQ_IDLE;
                  run_nxt = 1'b0;
               end else begin
                  st_nxt    = ADSQ_CONV;
                  sar_start = 1'b1;
                  later_nxt = 1'b1;
                  cnt_nxt   = adsq_conv_states(spd, 1'b1);
                  cur_nxt   = cur_r == last_ch ? first_ch
                                               : cur_r + 4'h1;
               end
            end
         end
         default: st_nxt = ADSQ_IDLE;
      endcase
      // software clear stops immediately and aborts the engine
      if (run_r && soft_clr && st_r != ADSQ_IDLE) begin
         st_nxt    = ADSQ_IDLE;
         sar_abort = 1'b1;
         sar_start = 1'b0;
         run_nxt   = 1'b0;
      end
      // set only at single end or scan pass end; hardware set wins
      // over a software clear landing in the same cycle
      if (result_cycle && (!scan_r || cur_r == last_ch))
         done_nxt = 1'b1;
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         ctrl_r  <= ADSQ_CTRL_RST;
         done_r  <= 1'b0;
         ien_r   <= 1'b0;
         run_r   <= 1'b0;
         scan_r  <= 1'b0;
         chsel_r <= 4'h0;
         cur_r   <= 4'h0;
         later_r <= 1'b0;
         cnt_r   <= 10'h000;
         st_r    <= ADSQ_IDLE;
         ext_q_r <= 1'b1;
      end else begin
         ctrl_r  <= ctrl_nxt;
         done_r  <= done_nxt;
         ien_r   <= ien_nxt;
         run_r   <= run_nxt;
         scan_r  <= scan_nxt;
         chsel_r <= chsel_nxt;
         cur_r   <= cur_nxt;
         later_r <= later_nxt;
         cnt_r   <= cnt_nxt;
         st_r    <= st_nxt;
         ext_q_r <= ext_q_nxt;
      end
   end

   // per-channel result store, written at each conversion end on inputs 0..11
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < ADSQ_CHANNELS; i++)
            data_r[i] <= '0;
      end else if (result_cycle && cur_r < 4'(ADSQ_CHANNELS)) begin
         data_r[cur_r] <= sar_result;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read mux; data words from flip-flops, unmapped reads zero
   logic [31:0] rd_mux, rdat_r;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (wb_adr_in == ADSQ_STATUS_OFS)
         rd_mux[7:0] = {done_r, ien_r, run_r, scan_r, chsel_r};
      else if (wb_adr_in == ADSQ_CTRL_OFS)
         rd_mux[7:0] = ctrl_r | ADSQ_CTRL_ONES;
      else if (wb_adr_in >= ADSQ_DATA_OFS &&
               wb_adr_in < ADSQ_DATA_OFS + 8'(4 * ADSQ_CHANNELS) &&
               wb_adr_in[1:0] == 2'b00)
         rd_mux[RES_BITS-1:0] = data_r[4'((wb_adr_in - ADSQ_DATA_OFS) >> 2)];
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in)
         rdat_r <= 32'h0000_0000;
      else
         rdat_r <= rd_mux;
   end

   assign wb_dat_out         = rdat_r;
   assign sample_channel_out = cur_r;
   assign done_interrupt_out = done_r && ien_r;

   ////////////////////////////////////////////////////////////////////
   // assertions
   a_single_clears_run: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (result_cycle && !scan_r && !soft_clr) |=> (!run_r && st_r == ADSQ_IDLE))
      else $error("single conversion did not clear run bit");
   a_run_during_conv: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (st_r != ADSQ_IDLE) |-> run_r)
      else $error("run bit low during conversion");
   a_ctrl_ones_read: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (ctrl_r & ADSQ_CTRL_ONES) == ADSQ_CTRL_ONES)
      else $error("reserved control bits not one");
   a_done_on_pass: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (result_cycle && (!scan_r || cur_r == last_ch)) |=> done_r)
      else $error("done flag not set at pass end");
   a_irq_on_single: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (result_cycle && !scan_r && ien_r && !wr_stat) |=> done_interrupt_out)
      else $error("single completion raised no interrupt");
   a_scan_wraps: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (result_cycle && scan_r && cur_r == last_ch && !soft_clr)
         |=> (cur_r == first_ch && st_r == ADSQ_CONV))
      else $error("scan did not restart at group start");
   a_ext_start: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (trg == ADSQ_TRG_EXT && ext_fall) |=> run_r)
      else $error("external falling edge did not set run");
   a_stop_idle: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (soft_clr && run_r) |=> (st_r == ADSQ_IDLE && !run_r))
      else $error("clearing run did not stop");
   a_soft_only_idle: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (st_r == ADSQ_IDLE && !wr_stat && trg != ADSQ_TRG_TIMER &&
       trg != ADSQ_TRG_EXT) |=> (st_r == ADSQ_IDLE))
      else $error("hardware trigger started while not selected");
   a_scan_later_len: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (result_cycle && scan_r && !soft_clr && !wr_ctrl)
         |=> (cnt_r == (ADSQ_T_SCAN_0 >> spd)))
      else $error("later scan conversion length wrong");
   a_data_stored: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (result_cycle && cur_r < 4'(ADSQ_CHANNELS))
         |=> (data_r[$past(cur_r)] == $past(sar_result)))
      else $error("result not stored under its channel");
   a_scan_first_ch: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (go && wr_stat && wb_dat_in[ADSQ_SCAN_BIT]) |=> (cur_r == first_ch))
      else $error("scan did not begin at group start");

endmodule // adsq_top

// ---- verification/adsq_cmp_model.sv ----
// analog side: comparator of a sar core with a fixed level per channel
// assumes trial code and channel come from the sequencer's registers
`timescale 1ns/1ps
module adsq_cmp_model (
   input  wire logic [9:0] trial_in,
   input  wire logic [3:0] channel_in,
   output logic            comparator_out
);
   ////////////////////////////////////////////////////////////////////////
   // level of input n is {n, 6'h15}, so each data register is distinct
   // and a result stored under the wrong channel shows at once
   assign comparator_out = ({channel_in, 6'h15} >= trial_in);
endmodule // adsq_cmp_model

// ---- verification/tb_top.sv ----
// self-checking bench of the a/d sequencer: registers, single, scan, triggers
// assumes adsq_top with one wait state wishbone and the comparator model
`timescale 1ns/1ps
module tb_top;
   import adsq_pkg::*;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } adsq_row_type;
   logic        clock_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tmr = 1'b0, ext = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [9:0]  trial;
   logic [3:0]  chan, prev;
   logic        ack, irq, cmp;
   logic [3:0]  seq [4];
   int          tt [4];
   int          n_mismatch = 0, n_tests = 0, cycles = 0, t0, k;
   int          tmax [4] = '{530, 266, 134, 68};
   adsq_row_type rows [12] = '{
      '{1'b0, 8'h00, 32'h0, 32'h00}, '{1'b0, 8'h04, 32'h0, 32'h33},
      '{1'b1, 8'h04, 32'hff, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'hff},
      '{1'b1, 8'h04, 32'h00, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h33},
      '{1'b0, 8'h10, 32'h0, 32'h00}, '{1'b0, 8'h3c, 32'h0, 32'h00},
      '{1'b1, 8'hfc, 32'hff, 32'h0}, '{1'b0, 8'hfc, 32'h0, 32'h00},
      '{1'b1, 8'h00, 32'h0b, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'h0b}};

   always #12.5 clock_in = ~clock_in;

   adsq_top #(.RES_BITS(10), .SETTLE(4)) adsq_top_i (
      .clock_in(clock_in), .resetn_in(resetn_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .timer_trigger_in(tmr), .ext_trigger_pin_in(ext),
      .comparator_in(cmp), .trial_code_out(trial),
      .sample_channel_out(chan), .done_interrupt_out(irq));
   adsq_cmp_model adsq_cmp_model_i (
      .trial_in(trial), .channel_in(chan), .comparator_out(cmp));

   ////////////////////////////////////////////////////////////////////////
   // cycle count and hang guard; the whole run needs about 2100 cycles
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic conclude();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clock_in);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge clock_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      if (n >= 50) chk(1'b0, 1'b1);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   // status polling; each poll is a full bus cycle, so no timing here
   task automatic wait_done();
      int i;
      i = 0;
      q = 32'h0;
      while (q[7] !== 1'b1 && i < 300) begin
         wb(1'b0, ADSQ_STATUS_OFS, 32'h0, q);
         i++;
      end
      chk(q[7], 1'b1);
   endtask

   function automatic logic [31:0] expv(input logic [3:0] n);
      return {22'h0, n, 6'h15};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clock_in);
      resetn_in <= 1'b1;
      // register table and reset values, one row per access
      foreach (rows[i]) begin
         if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d, q);
         else rdc(rows[i].a, rows[i].e);
      end
      // single mode at each speed code, timed from the start write
      for (int s = 0; s < 4; s++) begin
         wb(1'b1, ADSQ_CTRL_OFS, 32'(s << 2), q);
         rdc(ADSQ_CTRL_OFS, 32'(s << 2) | 32'h33);
         wb(1'b1, ADSQ_STATUS_OFS, 32'h60 | 32'(s), q);
         t0 = cycles;
         rdc(ADSQ_STATUS_OFS, 32'h60 | 32'(s));
         chk(chan, 4'(s));
         k = 0;
         while (irq !== 1'b1 && k < 1000) begin
            @(posedge clock_in);
            k++;
         end
         k = cycles - t0;
         chk(k inside {[tmax[s] - 16 : tmax[s] + 2]}, 1'b1);
         rdc(ADSQ_STATUS_OFS, 32'hc0 | 32'(s));
         rdc(ADSQ_DATA_OFS + 8'(4 * s), expv(4'(s)));
         wb(1'b1, ADSQ_STATUS_OFS, 32'h0, q);
         // the clear lands at the ack edge; look one edge later
         @(posedge clock_in);
         chk(irq, 1'b0);
      end
      // single on the upper group selects input 9
      wb(1'b1, ADSQ_STATUS_OFS, 32'h29, q);
      wait_done();
      rdc(ADSQ_DATA_OFS + 8'h24, expv(4'h9));
      rdc(ADSQ_STATUS_OFS, 32'h89);
      // scan of inputs 4..6 with interrupt enabled
      wb(1'b1, ADSQ_STATUS_OFS, 32'h76, q);
      prev = chan;
      k = 0;
      repeat (450) begin
         @(posedge clock_in);
         if (chan !== prev && k < 4) begin
            seq[k] = chan;
            tt[k] = cycles;
            k++;
         end
         prev = chan;
      end
      chk({seq[0], seq[1], seq[2]}, 12'h456);
      chk(seq[3], 4'h4);
      chk(tt[2] - tt[1], 64);
      chk(irq, 1'b1);
      for (int n = 4; n < 7; n++)
         rdc(ADSQ_DATA_OFS + 8'(4 * n), expv(4'(n)));
      wb(1'b1, ADSQ_STATUS_OFS, 32'h0, q);
      // a channel step may land at the stop edge itself
      @(posedge clock_in);
      prev = chan;
      repeat (200) @(posedge clock_in);
      chk(chan, prev);
      rdc(ADSQ_STATUS_OFS, 32'h0);
      // trigger sources: 00 timer, 01 timer, 00 pin, 11 pin
      for (int j = 0; j < 4; j++) begin
         wb(1'b1, ADSQ_CTRL_OFS,
            (j == 1) ? 32'h4c : (j == 3) ? 32'hcc : 32'h0c, q);
         wb(1'b1, ADSQ_STATUS_OFS, 32'h07, q);
         @(posedge clock_in);
         if (j < 2) tmr <= 1'b1;
         else ext <= 1'b0;
         @(posedge clock_in);
         tmr <= 1'b0;
         repeat (2) @(posedge clock_in);
         rdc(ADSQ_STATUS_OFS, j[0] ? 32'h27 : 32'h07);
         if (j[0]) begin
            wait_done();
            rdc(ADSQ_DATA_OFS + 8'h1c, expv(4'h7));
         end
         ext <= 1'b1;
         wb(1'b1, ADSQ_STATUS_OFS, 32'h0, q);
      end
      conclude();
   end
endmodule // tb_top
